/* inc/eu_pkg.sv */
/*
 * Shared constants and carrier types of the exception flagging unit.
 * Assumes one core clock and a plain strobe-style register port.
 */
package eu_pkg;

  // Register word offsets (byte addresses)
  localparam logic [7:0] OFS_TASK_STATE = 8'h00;
  localparam logic [7:0] OFS_SAVED_TASK_STATE = 8'h04;
  localparam logic [7:0] OFS_RETURN_PTR = 8'h08;
  localparam logic [7:0] OFS_SERVICE_TABLE = 8'h0c;
  localparam logic [7:0] OFS_CAUSE = 8'h10;
  localparam logic [7:0] OFS_FLAG = 8'h14;
  localparam logic [7:0] OFS_CLEAR = 8'h18;
  localparam logic [7:0] OFS_RESUME = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;

  // Task state field positions
  localparam int TS_XEN = 2;
  localparam int TS_INT = 3;
  localparam int TS_LOOP = 9;
  localparam int TS_BRANCH = 10;
  localparam int TS_MODE_LO = 6;

  // Cause and flag bit positions
  localparam int CAUSE_CONFLICT = 6;
  localparam int FLAG_INTERNAL = 1;

  // Return pointer compare mask and service table layout
  localparam logic [31:0] FETCH_MASK = 32'hffff_fe1f;
  localparam logic [31:0] TABLE_BASE_MASK = 32'hffff_fc00;
  localparam int VEC_LSB = 5;

  // Exception entry address offset from the service table base
  localparam logic [31:0] EXC_VEC_OFS = 32'h0000_0020;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0] RST_IRQ = 3'h0;

  // Interrupt event bits
  localparam int EV_TAKEN = 0;
  localparam int EV_DRAIN_CONFLICT = 1;
  localparam int EV_RESUMED = 2;

  typedef struct packed {
    logic vld;
    logic pre_ex;
    logic [3:0] slot;
    logic [5:0] dest;
  } eu_wport_t;

  typedef struct packed {
    logic int_f;
    logic loop_act;
    logic br_pend;
    logic [1:0] mode;
    logic [31:0] pc;
  } eu_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } eu_bus_req_t;

endpackage : eu_pkg

/* core/eu_conflict.sv */
/*
 * Write-port annul and conflict detector for two result paths.
 * Assumes port fields come from pipeline logic on the same clock.
 */
`timescale 1ns/100ps
module eu_conflict (
  input wire logic clk,
  input wire logic rst_n,
  input eu_pkg::eu_wport_t wp0,
  input eu_pkg::eu_wport_t wp1,
  input wire logic drain,
  output logic wen0,
  output logic wen1,
  output logic conflict
);

  function automatic logic live(input eu_pkg::eu_wport_t p,
                                input logic dr);
    live = p.vld && !(dr && p.pre_ex);
  endfunction : live

  // While draining, annul writes that have not reached the first execute phase
  assign wen0 = live(wp0, drain);
  assign wen1 = live(wp1, drain);

  // Only surviving writes take part in the compare
  assign conflict = wen0 && wen1 && (wp0.dest == wp1.dest)
                    && (wp0.slot != wp1.slot);

  property p_annul_no_write;
    @(posedge clk) disable iff (!rst_n)
      (drain && wp0.pre_ex) |-> !wen0 && !conflict;
  endproperty
  a_annul_no_write: assert property (p_annul_no_write)
    else $error("annulled write still enabled");

  property p_conflict_cause;
    @(posedge clk) disable iff (!rst_n)
      (wp0.vld && wp1.vld && !drain && wp0.dest == wp1.dest
       && wp0.slot != wp1.slot) |-> conflict;
  endproperty
  a_conflict_cause: assert property (p_conflict_cause)
    else $error("same-cycle double write not flagged");

  property p_annul_no_conflict;
    @(posedge clk) disable iff (!rst_n)
      conflict |-> !(drain && (wp0.pre_ex || wp1.pre_ex));
  endproperty
  a_annul_no_conflict: assert property (p_annul_no_conflict)
    else $error("annulled packet raised conflict");

endmodule : eu_conflict

/* core/eu_unit.sv */
/*
 * Exception flagging and recovery unit of the core.
 * Assumes pipeline status inputs on the core clock and a strobe
 * register port with read data one cycle after the read strobe.
 */
// Decided for this implementation: the register offsets and the plain strobed port.
// Contract
// - Drain conflict is only pended, never taken mid-execution.
// - Pended drain conflict is taken when the handler is reached.
// - Return pointer and saved state capture arrival state at handler.
// - Saved state shows context switch 1, loop 0, branch 0, mode 00.
// - Saved return pointer matches service table under mask ffff_fe1f.
// - Conflict sets the conflict cause bit only.
// - Conflict sets the internal exception flag only.
// - Writing 2 to the clear register clears the internal flag.
// - Resume write branches to the saved return pointer.
// - Different-slot same-cycle writes to one register raise a conflict.
// - Draining annuls writes not yet in the first execute phase.
// - Exceptions are raised only with global exception enable set; a pended one is still taken at arrival if the enable was cleared meanwhile.
`timescale 1ns/100ps
module eu_unit (
  input wire logic clk,
  input wire logic rst_n,
  input eu_pkg::eu_bus_req_t bus,
  output logic [31:0] rdata,
  input eu_pkg::eu_wport_t wp0,
  input eu_pkg::eu_wport_t wp1,
  input wire logic drain,
  input wire logic arrive,
  input wire logic [3:0] vec,
  input eu_pkg::eu_state_t state,
  output logic wen0,
  output logic wen1,
  output logic exc_take,
  output logic redirect_vld,
  output logic [31:0] redirect_pc,
  output logic irq
);

  typedef enum logic [2:0] {
    EU_IDLE = 3'b001,
    EU_PEND = 3'b010,
    EU_HELD = 3'b100
  } eu_fsm_t;

  eu_fsm_t st_q;
  eu_fsm_t st_d;
  logic xen_q;
  logic [31:0] tbl_q;
  logic [31:0] ret_q;
  logic [31:0] sav_q;
  logic [31:0] cause_q;
  logic [31:0] flag_q;
  logic [2:0] ist_q;
  logic [2:0] ien_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic exc_take_q;
  logic redir_q;
  logic [31:0] redir_pc_q;
  logic conflict;
  logic take_now;
  logic take_arrive;
  logic take_any;
  logic resume_wr;
  logic clear_wr;
  logic [31:0] handler_pc;
  logic [2:0] ev;

  function automatic logic [31:0] pack_state(input eu_pkg::eu_state_t s,
                                             input logic g);
    logic [31:0] w;
    w = eu_pkg::RST_WORD;
    w[eu_pkg::TS_XEN] = g;
    w[eu_pkg::TS_INT] = s.int_f;
    w[eu_pkg::TS_LOOP] = s.loop_act;
    w[eu_pkg::TS_BRANCH] = s.br_pend;
    w[eu_pkg::TS_MODE_LO +: 2] = s.mode;
    pack_state = w;
  endfunction : pack_state

  function automatic logic hit(input eu_pkg::eu_bus_req_t b,
                               input logic [7:0] ofs);
    hit = (b.addr == ofs);
  endfunction : hit

  eu_conflict u_conflict (
    .clk(clk),
    .rst_n(rst_n),
    .wp0(wp0),
    .wp1(wp1),
    .drain(drain),
    .wen0(wen0),
    .wen1(wen1),
    .conflict(conflict)
  );

  // Handler entry address lies in the service table
  assign handler_pc = (tbl_q & eu_pkg::TABLE_BASE_MASK)
                      | (32'(vec) << eu_pkg::VEC_LSB);

  // Ordinary execution takes at once; draining defers to handler
  assign take_now = conflict && xen_q && !drain
                    && (st_q == EU_IDLE);
  assign take_arrive = arrive && (st_q == EU_PEND);
  assign take_any = take_now || take_arrive;

  assign resume_wr = bus.wr && hit(bus, eu_pkg::OFS_RESUME);
  assign clear_wr = bus.wr && hit(bus, eu_pkg::OFS_CLEAR);

  always_comb begin
    st_d = st_q;
    case (st_q)
      EU_IDLE: begin
        if (conflict && xen_q && drain) begin
          st_d = EU_PEND;
        end else if (take_now) begin
          st_d = EU_HELD;
        end
      end
      EU_PEND: begin
        if (arrive) begin
          st_d = EU_HELD;
        end
      end
      EU_HELD: begin
        if (resume_wr) begin
          st_d = EU_IDLE;
        end
      end
      default: begin
        st_d = EU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= EU_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Software-owned control
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xen_q <= 1'b0;
      tbl_q <= eu_pkg::RST_WORD;
    end else if (bus.wr) begin
      if (hit(bus, eu_pkg::OFS_TASK_STATE)) begin
        xen_q <= bus.wdata[eu_pkg::TS_XEN];
      end
      if (hit(bus, eu_pkg::OFS_SERVICE_TABLE)) begin
        tbl_q <= bus.wdata & eu_pkg::TABLE_BASE_MASK;
      end
    end
  end

  // Saved machine state on exception entry
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ret_q <= eu_pkg::RST_WORD;
      sav_q <= eu_pkg::RST_WORD;
    end else if (take_arrive) begin
      ret_q <= handler_pc;
      sav_q <= pack_state('{int_f: 1'b1, loop_act: 1'b0, br_pend: 1'b0,
                            mode: 2'h0, pc: handler_pc},
                          xen_q);
    end else if (take_now) begin
      ret_q <= state.pc;
      sav_q <= pack_state(state, xen_q);
    end
  end

  // Cause register: hardware set wins over software write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cause_q <= eu_pkg::RST_WORD;
    end else if (take_any) begin
      cause_q <= 32'h0000_0001 << eu_pkg::CAUSE_CONFLICT;
    end else if (bus.wr && hit(bus, eu_pkg::OFS_CAUSE)) begin
      cause_q <= bus.wdata;
    end
  end

  // Flag register: clear writes ones, a new exception wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= eu_pkg::RST_WORD;
    end else if (take_any) begin
      flag_q <= 32'h0000_0001 << eu_pkg::FLAG_INTERNAL;
    end else if (clear_wr) begin
      flag_q <= flag_q & ~bus.wdata;
    end
  end

  // Take pulse and fetch redirect
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exc_take_q <= 1'b0;
      redir_q <= 1'b0;
      redir_pc_q <= eu_pkg::RST_WORD;
    end else begin
      exc_take_q <= take_any;
      redir_q <= take_any || resume_wr;
      if (take_any) begin
        redir_pc_q <= tbl_q | eu_pkg::EXC_VEC_OFS;
      end else if (resume_wr) begin
        redir_pc_q <= ret_q;
      end
    end
  end

  assign exc_take = exc_take_q;
  assign redirect_vld = redir_q;
  assign redirect_pc = redir_pc_q;

  // Interrupt status, enable and level output
  assign ev = {resume_wr, conflict && drain && xen_q, take_any};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ist_q <= eu_pkg::RST_IRQ;
    end else if (bus.wr && hit(bus, eu_pkg::OFS_IRQ_CLEAR)) begin
      ist_q <= (ist_q & ~bus.wdata[2:0]) | ev;
    end else begin
      ist_q <= ist_q | ev;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ien_q <= eu_pkg::RST_IRQ;
    end else if (bus.wr && hit(bus, eu_pkg::OFS_IRQ_ENABLE)) begin
      ien_q <= bus.wdata[2:0];
    end
  end

  assign irq = |(ist_q & ien_q);

  // Read path, data valid one cycle after the strobe
  always_comb begin
    rdata_d = eu_pkg::RST_WORD;
    case (bus.addr)
      eu_pkg::OFS_TASK_STATE: rdata_d = pack_state(state, xen_q);
      eu_pkg::OFS_SAVED_TASK_STATE: rdata_d = sav_q;
      eu_pkg::OFS_RETURN_PTR: rdata_d = ret_q;
      eu_pkg::OFS_SERVICE_TABLE: rdata_d = tbl_q;
      eu_pkg::OFS_CAUSE: rdata_d = cause_q;
      eu_pkg::OFS_FLAG: rdata_d = flag_q;
      eu_pkg::OFS_IRQ_STATUS: rdata_d = {29'h0, ist_q};
      eu_pkg::OFS_IRQ_ENABLE: rdata_d = {29'h0, ien_q};
      default: rdata_d = eu_pkg::RST_WORD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= eu_pkg::RST_WORD;
    end else if (bus.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= eu_pkg::RST_WORD;
    end
  end

  assign rdata = rdata_q;

  property p_no_take_while_drain;
    @(posedge clk) disable iff (!rst_n)
      (drain && !arrive) |=> !exc_take;
  endproperty
  a_no_take_while_drain: assert property (p_no_take_while_drain)
    else $error("exception taken during drain");

  property p_take_at_arrive;
    @(posedge clk) disable iff (!rst_n)
      (st_q == EU_PEND && arrive) |=> exc_take && st_q == EU_HELD;
  endproperty
  a_take_at_arrive: assert property (p_take_at_arrive)
    else $error("pended exception not taken at handler");

  property p_ret_handler;
    @(posedge clk) disable iff (!rst_n)
      take_arrive |=> ret_q == $past(handler_pc);
  endproperty
  a_ret_handler: assert property (p_ret_handler)
    else $error("return pointer not captured at handler");

  property p_sav_fields;
    @(posedge clk) disable iff (!rst_n)
      take_arrive |=> sav_q[eu_pkg::TS_INT] && !sav_q[eu_pkg::TS_LOOP]
        && !sav_q[eu_pkg::TS_BRANCH]
        && sav_q[eu_pkg::TS_MODE_LO +: 2] == 2'h0;
  endproperty
  a_sav_fields: assert property (p_sav_fields)
    else $error("saved task state fields wrong");

  property p_ret_mask;
    @(posedge clk) disable iff (!rst_n)
      take_arrive |=> (ret_q & eu_pkg::FETCH_MASK)
        == (tbl_q & eu_pkg::FETCH_MASK);
  endproperty
  a_ret_mask: assert property (p_ret_mask)
    else $error("return pointer outside service table");

  property p_cause_only;
    @(posedge clk) disable iff (!rst_n)
      take_any |=> cause_q == (32'h1 << eu_pkg::CAUSE_CONFLICT)
        && exc_take;
  endproperty
  a_cause_only: assert property (p_cause_only)
    else $error("cause register wrong after conflict");

  property p_flag_only;
    @(posedge clk) disable iff (!rst_n)
      take_any |=> flag_q == (32'h1 << eu_pkg::FLAG_INTERNAL);
  endproperty
  a_flag_only: assert property (p_flag_only)
    else $error("flag register wrong after conflict");

  property p_clear_two;
    @(posedge clk) disable iff (!rst_n)
      (clear_wr && bus.wdata == 32'h2 && !take_any)
        |=> !flag_q[eu_pkg::FLAG_INTERNAL];
  endproperty
  a_clear_two: assert property (p_clear_two)
    else $error("clear write left internal flag set");

  property p_resume;
    @(posedge clk) disable iff (!rst_n)
      (resume_wr && !take_any) |=> redirect_vld
        && redirect_pc == $past(ret_q);
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not branch to return pointer");

  property p_xen_gate;
    @(posedge clk) disable iff (!rst_n)
      (!xen_q && st_q == EU_IDLE) |=> !exc_take;
  endproperty
  a_xen_gate: assert property (p_xen_gate)
    else $error("exception raised while disabled");

  property p_valid_conflict;
    @(posedge clk) disable iff (!rst_n)
      (conflict && xen_q && !drain && st_q == EU_IDLE) |=> exc_take;
  endproperty
  a_valid_conflict: assert property (p_valid_conflict)
    else $error("valid conflict not taken");

endmodule : eu_unit

/* tb/tb.sv */
/*
 * Self-checking bench for the exception flagging unit.
 * Assumes the eu_unit ports and the register offsets of eu_pkg.
 */
`timescale 1ns/100ps
module tb;
  localparam logic [31:0] BASE = 32'h0000_1400;
  logic clk;
  logic rst_n;
  eu_pkg::eu_bus_req_t bus;
  eu_pkg::eu_wport_t wp0;
  eu_pkg::eu_wport_t wp1;
  eu_pkg::eu_state_t state;
  logic [31:0] rdata;
  logic [31:0] redirect_pc;
  logic [31:0] v;
  logic [3:0] vec;
  logic drain;
  logic arrive;
  logic wen0;
  logic wen1;
  logic w0;
  logic w1;
  logic exc_take;
  logic redirect_vld;
  logic irq;
  logic [7:0] ro_ofs [9];
  int n_fail;
  int checks;

  eu_unit dut (
    .clk(clk),
    .rst_n(rst_n),
    .bus(bus),
    .rdata(rdata),
    .wp0(wp0),
    .wp1(wp1),
    .drain(drain),
    .arrive(arrive),
    .vec(vec),
    .state(state),
    .wen0(wen0),
    .wen1(wen1),
    .exc_take(exc_take),
    .redirect_vld(redirect_vld),
    .redirect_pc(redirect_pc),
    .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // Two writes in one cycle; wen sampled while they stand
  task automatic cfl(input logic [3:0] s0, input logic [3:0] s1,
                     input logic [5:0] d1, input logic pe);
    @(posedge clk);
    wp0 <= '{vld: 1'b1, pre_ex: pe, slot: s0, dest: 6'h05};
    wp1 <= '{vld: 1'b1, pre_ex: pe, slot: s1, dest: d1};
    #1;
    w0 = wen0;
    w1 = wen1;
    @(posedge clk);
    wp0 <= '0;
    wp1 <= '0;
    #1;
  endtask : cfl

  task automatic arr(input logic [3:0] vv);
    @(posedge clk);
    arrive <= 1'b1;
    vec <= vv;
    @(posedge clk);
    arrive <= 1'b0;
    #1;
  endtask : arr

  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    n_fail = 0;
    checks = 0;
    ro_ofs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h28,
               8'h30};
    rst_n = 1'b0;
    bus = '0;
    wp0 = '0;
    wp1 = '0;
    state = '0;
    drain = 1'b0;
    arrive = 1'b0;
    vec = 4'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, unmapped offset reads zero
    foreach (ro_ofs[i]) begin
      rd(ro_ofs[i], v);
      chk("reset read", 32'h0, v);
    end
    // Exceptions disabled
    cfl(4'h1, 4'h2, 6'h05, 1'b0);
    chk("take en off", 32'h0, {31'h0, exc_take});
    wr(eu_pkg::OFS_SERVICE_TABLE, BASE | 32'h3ff);
    rd(eu_pkg::OFS_SERVICE_TABLE, v);
    chk("table", BASE, v);
    wr(eu_pkg::OFS_IRQ_ENABLE, 32'h7);
    wr(eu_pkg::OFS_TASK_STATE, 32'h4);
    rd(eu_pkg::OFS_TASK_STATE, v);
    chk("enable", 32'h4, v);
    // Same slot, or different register: no conflict
    cfl(4'h3, 4'h3, 6'h05, 1'b0);
    chk("same slot", 32'h0, {31'h0, exc_take});
    cfl(4'h1, 4'h2, 6'h06, 1'b0);
    chk("diff dest", 32'h0, {31'h0, exc_take});
    // Conflict in ordinary execution is taken at once
    cfl(4'h1, 4'h2, 6'h05, 1'b0);
    chk("take now", 32'h1, {31'h0, exc_take});
    chk("redir now", 32'h1, {31'h0, redirect_vld});
    chk("vector", BASE | 32'h20, redirect_pc);
    chk("irq", 32'h1, {31'h0, irq});
    rd(eu_pkg::OFS_SAVED_TASK_STATE, v);
    chk("saved now", 32'h4, v);
    rd(eu_pkg::OFS_CAUSE, v);
    chk("cause", 32'h40, v);
    rd(eu_pkg::OFS_FLAG, v);
    chk("flag", 32'h2, v);
    wr(eu_pkg::OFS_CLEAR, 32'h2);
    rd(eu_pkg::OFS_FLAG, v);
    chk("flag clr", 32'h0, v);
    wr(eu_pkg::OFS_RESUME, 32'h0);
    chk("resume", 32'h1, {31'h0, redirect_vld});
    chk("resume pc now", 32'h0, redirect_pc);
    wr(eu_pkg::OFS_IRQ_CLEAR, 32'h7);
    chk("irq clr", 32'h0, {31'h0, irq});
    // Draining: annulled writes never conflict
    @(posedge clk);
    drain <= 1'b1;
    cfl(4'h1, 4'h2, 6'h05, 1'b1);
    chk("annul", 32'h0, {30'h0, w0, w1});
    arr(4'h2);
    chk("annul take", 32'h0, {31'h0, exc_take});
    // Draining: conflict pends until the handler is reached
    cfl(4'h1, 4'h2, 6'h05, 1'b0);
    chk("wen drain", 32'h3, {30'h0, w0, w1});
    chk("pend", 32'h0, {31'h0, exc_take});
    repeat (2) @(posedge clk);
    state <= '{int_f: 1'b1, loop_act: 1'b0, br_pend: 1'b0, mode: 2'h0,
               pc: 32'h1234_5678};
    #1;
    chk("pend hold", 32'h0, {31'h0, exc_take});
    arr(4'h2);
    chk("take arrive", 32'h1, {31'h0, exc_take});
    @(posedge clk);
    drain <= 1'b0;
    rd(eu_pkg::OFS_SAVED_TASK_STATE, v);
    chk("saved state", 32'h8, v & 32'h6c8);
    rd(eu_pkg::OFS_RETURN_PTR, v);
    chk("return ptr", BASE | 32'h40, v);
    chk("fetch mask", BASE & eu_pkg::FETCH_MASK,
        v & eu_pkg::FETCH_MASK);
    rd(eu_pkg::OFS_IRQ_STATUS, v);
    chk("irq status", 32'h3, v);
    rd(eu_pkg::OFS_CAUSE, v);
    chk("cause drain", 32'h40, v);
    rd(eu_pkg::OFS_FLAG, v);
    chk("flag drain", 32'h2, v);
    wr(eu_pkg::OFS_CLEAR, 32'h2);
    rd(eu_pkg::OFS_FLAG, v);
    chk("flag clr2", 32'h0, v);
    wr(eu_pkg::OFS_RESUME, 32'h0);
    chk("resume2", 32'h1, {31'h0, redirect_vld});
    chk("resume pc", BASE | 32'h40, redirect_pc);
    // Masked status keeps the line low
    wr(eu_pkg::OFS_IRQ_ENABLE, 32'h0);
    chk("irq mask", 32'h0, {31'h0, irq});
    end_of_test();
  end
endmodule : tb
